// ==== include/xel_cfg.svh ====
// Constants for the translation unit error logging block.
// Assumes a 32-bit register port with byte addresses and 16-bit registers.
`ifndef XEL_CFG_SVH
`define XEL_CFG_SVH

// Widths and unit count.
`define XEL_ADDR_W        8
`define XEL_DATA_W        32
`define XEL_REG_W         16
`define XEL_UNITS         2
`define XEL_PRIMARY       0
`define XEL_SECONDARY     1

// Register byte offsets.
`define XEL_OFS_P_STATUS  8'h00
`define XEL_OFS_P_ISR     8'h04
`define XEL_OFS_P_MASK    8'h08
`define XEL_OFS_S_STATUS  8'h0C
`define XEL_OFS_S_ISR     8'h10
`define XEL_OFS_S_MASK    8'h14
`define XEL_OFS_CONTROL   8'h18

// Status register bit.
`define XEL_SR_SERR_ASSERTED   14

// Interrupt status register bits.
`define XEL_ISR_SERR_ASSERTED  10
`define XEL_ISR_IBMA           7
`define XEL_ISR_SERR_DETECTED  4

// Mask and control bits.
`define XEL_MASK_SERR_ASSERTED 6
`define XEL_CTL_P_DET_MASK     9
`define XEL_CTL_S_DET_MASK     10

// Writable bit sets and reset values.
`define XEL_SR_W1C_BITS   16'h4000
`define XEL_ISR_W1C_BITS  16'h0490
`define XEL_RST_REG       16'h0000
`define XEL_RST_WORD      32'h0000_0000
`define XEL_PIN_IDLE      1'b1
`define XEL_BIT_CLR       1'b0

`endif

// ==== include/xel_pkg.sv ====
// Types for the translation unit error logging block.
// Assumes xel_cfg.svh is on the include path.
`include "xel_cfg.svh"

package xel_pkg;

  // Register port request, all fields from the bus master's clock domain.
  typedef struct packed {
    logic [`XEL_ADDR_W-1:0] addr;
    logic [`XEL_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } xel_bus_req_t;

  // Internal-bus abort events of one unit, each a one-cycle pulse.
  typedef struct packed {
    logic ib_wr_ma;
    logic ib_wr_ta;
    logic ib_rd_ma;
    logic ib_rd_ta;
    logic ob_wr_ma;
    logic ob_wr_ta;
    logic ob_rd_ma;
    logic ob_rd_ta;
  } xel_abort_t;

  // Register kinds reached by the register port.
  typedef enum logic [2:0] {
    XEL_SEL_NONE    = 3'b000,
    XEL_SEL_STATUS  = 3'b001,
    XEL_SEL_ISR     = 3'b010,
    XEL_SEL_MASK    = 3'b011,
    XEL_SEL_CONTROL = 3'b100
  } xel_sel_t;

  // Result of an address decode.
  typedef struct packed {
    xel_sel_t sel;
    logic     unit;
  } xel_dec_t;

endpackage : xel_pkg

// ==== src/xel_top.sv ====
// Error logging for the internal-bus side of the primary and secondary translation units.
// Assumes abort pulses come from logic on clk and the system error pins are asynchronous.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "xel_cfg.svh"

// Function
// - Inbound master abort sets interrupt status bit 7.
// - Primary inbound write abort drives error, status 14.
// - Primary write abort sets bit 10, mask 6.
// - Primary error detected sets bit 4, control 9.
// - Secondary inbound write abort drives error, status 14.
// - Secondary write abort sets bit 10, mask 6.
// - Secondary error detected sets bit 4, control 10.
// - Outbound and inbound read target aborts log nothing.
// - Primary outbound read master abort logs nothing.
// - Secondary outbound read master abort logs nothing.
module xel_top import xel_pkg::*; (
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Register port.
  input  wire xel_bus_req_t           bus_req,
  output logic [`XEL_DATA_W-1:0]      bus_rdata,
  // Internal-bus abort events.
  input  wire xel_abort_t             primary_abort,
  input  wire xel_abort_t             secondary_abort,
  // Primary system error pin.
  input  wire logic                   primary_system_error_n_in,
  output logic                        primary_system_error_n_out,
  output logic                        primary_system_error_n_oe,
  // Secondary system error pin.
  input  wire logic                   secondary_system_error_n_in,
  output logic                        secondary_system_error_n_out,
  output logic                        secondary_system_error_n_oe,
  // Interrupt requests.
  output logic                        primary_irq,
  output logic                        secondary_irq,
  output logic                        irq
);

  // Maps a byte address onto a register kind and unit.
  function automatic xel_dec_t decode_addr(input logic [`XEL_ADDR_W-1:0] a);
    xel_dec_t d;
    d.sel  = XEL_SEL_NONE;
    d.unit = 1'b0;
    if (a == `XEL_OFS_P_STATUS) begin
      d.sel = XEL_SEL_STATUS;
    end else if (a == `XEL_OFS_P_ISR) begin
      d.sel = XEL_SEL_ISR;
    end else if (a == `XEL_OFS_P_MASK) begin
      d.sel = XEL_SEL_MASK;
    end else if (a == `XEL_OFS_S_STATUS) begin
      d.sel  = XEL_SEL_STATUS;
      d.unit = 1'b1;
    end else if (a == `XEL_OFS_S_ISR) begin
      d.sel  = XEL_SEL_ISR;
      d.unit = 1'b1;
    end else if (a == `XEL_OFS_S_MASK) begin
      d.sel  = XEL_SEL_MASK;
      d.unit = 1'b1;
    end else if (a == `XEL_OFS_CONTROL) begin
      d.sel = XEL_SEL_CONTROL;
    end
    return d;
  endfunction : decode_addr

  xel_dec_t                 wr_dec;
  xel_dec_t                 rd_dec;
  xel_abort_t               abort_w       [`XEL_UNITS];
  logic                     pin_n_w       [`XEL_UNITS];
  logic [`XEL_REG_W-1:0]    wr_word;

  logic [`XEL_REG_W-1:0]    status_reg    [`XEL_UNITS];
  logic [`XEL_REG_W-1:0]    status_next   [`XEL_UNITS];
  logic [`XEL_REG_W-1:0]    isr_reg       [`XEL_UNITS];
  logic [`XEL_REG_W-1:0]    isr_next      [`XEL_UNITS];
  logic [`XEL_REG_W-1:0]    mask_reg      [`XEL_UNITS];
  logic [`XEL_REG_W-1:0]    mask_next     [`XEL_UNITS];
  logic [`XEL_REG_W-1:0]    enable_w      [`XEL_UNITS];
  logic                     sync1_reg     [`XEL_UNITS];
  logic                     sync2_reg     [`XEL_UNITS];
  logic                     drive_reg     [`XEL_UNITS];
  logic                     drive_next    [`XEL_UNITS];
  logic                     irq_u_reg     [`XEL_UNITS];
  logic                     irq_u_next    [`XEL_UNITS];
  logic                     pin_out_reg   [`XEL_UNITS];
  logic                     pin_out_next  [`XEL_UNITS];
  logic                     ib_wr_abort_w [`XEL_UNITS];
  logic                     ib_ma_w       [`XEL_UNITS];
  logic                     wr_status_w   [`XEL_UNITS];
  logic                     wr_isr_w      [`XEL_UNITS];

  logic [`XEL_REG_W-1:0]    control_reg;
  logic [`XEL_REG_W-1:0]    control_next;
  logic [`XEL_DATA_W-1:0]   rdata_reg;
  logic [`XEL_DATA_W-1:0]   rdata_next;
  logic                     irq_reg;
  logic                     irq_next;

  // All checks run on clk and pause during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Per-unit views of the inputs.
  always_comb begin
    wr_dec     = decode_addr(bus_req.addr);
    rd_dec     = decode_addr(bus_req.addr);
    wr_word    = bus_req.wdata[`XEL_REG_W-1:0];
    abort_w[0] = primary_abort;
    abort_w[1] = secondary_abort;
    pin_n_w[0] = primary_system_error_n_in;
    pin_n_w[1] = secondary_system_error_n_in;
  end

  // Shared control register holds the detected-error masks of both units.
  always_comb begin
    control_next = control_reg;
    if (bus_req.wr && wr_dec.sel == XEL_SEL_CONTROL) begin
      control_next = wr_word;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control_reg <= `XEL_RST_REG;
    end else begin
      control_reg <= control_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `XEL_UNITS; g++) begin : g_unit
      // Event decode and interrupt enables of one unit.
      always_comb begin
        ib_wr_abort_w[g] = abort_w[g].ib_wr_ma | abort_w[g].ib_wr_ta;
        ib_ma_w[g]       = abort_w[g].ib_wr_ma | abort_w[g].ib_rd_ma;
        wr_status_w[g]   = bus_req.wr && wr_dec.sel == XEL_SEL_STATUS && wr_dec.unit == g;
        wr_isr_w[g]      = bus_req.wr && wr_dec.sel == XEL_SEL_ISR && wr_dec.unit == g;
        enable_w[g]      = `XEL_RST_REG;
        enable_w[g][`XEL_ISR_IBMA]          = 1'b1;
        enable_w[g][`XEL_ISR_SERR_ASSERTED] = ~mask_next[g][`XEL_MASK_SERR_ASSERTED];
        enable_w[g][`XEL_ISR_SERR_DETECTED] = (g == `XEL_PRIMARY) ?
                                              ~control_next[`XEL_CTL_P_DET_MASK] :
                                              ~control_next[`XEL_CTL_S_DET_MASK];
      end

      // Status bits clear on a written one, and a same-cycle event wins.
      always_comb begin
        status_next[g] = status_reg[g];
        isr_next[g]    = isr_reg[g];
        mask_next[g]   = mask_reg[g];
        if (wr_status_w[g]) begin
          status_next[g] = status_reg[g] & ~(wr_word & `XEL_SR_W1C_BITS);
        end
        if (wr_isr_w[g]) begin
          isr_next[g] = isr_reg[g] & ~(wr_word & `XEL_ISR_W1C_BITS);
        end
        if (bus_req.wr && wr_dec.sel == XEL_SEL_MASK && wr_dec.unit == g) begin
          mask_next[g] = wr_word;
        end
        if (ib_ma_w[g]) begin
          isr_next[g][`XEL_ISR_IBMA] = 1'b1;
        end
        if (ib_wr_abort_w[g]) begin
          status_next[g][`XEL_SR_SERR_ASSERTED] = 1'b1;
          isr_next[g][`XEL_ISR_SERR_ASSERTED]   = 1'b1;
        end
        if (!sync2_reg[g]) begin
          isr_next[g][`XEL_ISR_SERR_DETECTED] = 1'b1;
        end
        // Outbound aborts and inbound read target aborts reach no bit here.
        drive_next[g] = ib_wr_abort_w[g];
        pin_out_next[g] = ~ib_wr_abort_w[g];
        irq_u_next[g] = |(isr_next[g] & enable_w[g]);
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          status_reg[g] <= `XEL_RST_REG;
          isr_reg[g]    <= `XEL_RST_REG;
          mask_reg[g]   <= `XEL_RST_REG;
          sync1_reg[g]  <= `XEL_PIN_IDLE;
          sync2_reg[g]  <= `XEL_PIN_IDLE;
          drive_reg[g]  <= `XEL_BIT_CLR;
          pin_out_reg[g] <= `XEL_PIN_IDLE;
          irq_u_reg[g]  <= `XEL_BIT_CLR;
        end else begin
          status_reg[g] <= status_next[g];
          isr_reg[g]    <= isr_next[g];
          mask_reg[g]   <= mask_next[g];
          sync1_reg[g]  <= pin_n_w[g];
          sync2_reg[g]  <= sync1_reg[g];
          drive_reg[g]  <= drive_next[g];
          pin_out_reg[g] <= pin_out_next[g];
          irq_u_reg[g]  <= irq_u_next[g];
        end
      end

      // Checks of one unit.
      a_ibma_sets_bit7: assert property (ib_ma_w[g] |=> isr_reg[g][`XEL_ISR_IBMA])
        else $error("Inbound master abort did not set bit 7.");
      a_ibrd_no_status: assert property (
        (abort_w[g].ib_rd_ma && !ib_wr_abort_w[g] && !wr_status_w[g]) |=> $stable(status_reg[g]))
        else $error("Inbound read master abort changed the status register.");
      a_serr_pulse_drive: assert property (
        ib_wr_abort_w[g] |=> (drive_reg[g] && status_reg[g][`XEL_SR_SERR_ASSERTED]))
        else $error("Inbound write abort did not drive the system error pin.");
      a_serr_status_cause: assert property (
        $rose(status_reg[g][`XEL_SR_SERR_ASSERTED]) |-> $past(ib_wr_abort_w[g]))
        else $error("Status bit 14 set without an inbound write abort.");
      a_serr_isr_bit10: assert property (
        ib_wr_abort_w[g] |=> isr_reg[g][`XEL_ISR_SERR_ASSERTED])
        else $error("Inbound write abort did not set bit 10.");
      a_bit10_masked: assert property (
        (isr_reg[g] == (`XEL_ISR_W1C_BITS & 16'h0400) && mask_reg[g][`XEL_MASK_SERR_ASSERTED]
         && !ib_ma_w[g] && sync2_reg[g] && !wr_isr_w[g] && !ib_wr_abort_w[g]
         && !bus_req.wr) |=> !irq_u_reg[g])
        else $error("Masked bit 10 still raised the interrupt.");
      a_detect_bit4: assert property (
        (!pin_n_w[g]) [*2] |=> ##1 isr_reg[g][`XEL_ISR_SERR_DETECTED])
        else $error("Low system error pin was not logged in bit 4.");
      a_detect_cause: assert property (
        $rose(isr_reg[g][`XEL_ISR_SERR_DETECTED]) |-> $past(!sync2_reg[g]))
        else $error("Bit 4 set while the pin was not low.");
      a_outbound_quiet: assert property (
        ((abort_w[g].ob_wr_ma || abort_w[g].ob_wr_ta || abort_w[g].ob_rd_ta || abort_w[g].ib_rd_ta)
         && !ib_ma_w[g] && !ib_wr_abort_w[g] && sync2_reg[g] && !bus_req.wr)
        |=> ($stable(isr_reg[g]) && $stable(status_reg[g]) && !drive_reg[g]))
        else $error("Outbound or inbound read target abort logged an error.");
      a_drc_quiet: assert property (
        (abort_w[g].ob_rd_ma && !ib_ma_w[g] && !ib_wr_abort_w[g] && sync2_reg[g] && !bus_req.wr)
        |=> ($stable(isr_reg[g]) && $stable(status_reg[g])))
        else $error("Outbound read master abort logged an error.");
      a_irq_follows: assert property (
        isr_reg[g][`XEL_ISR_IBMA] |-> irq_u_reg[g] && irq_reg)
        else $error("Set unmasked bit 7 did not raise the interrupt.");
      a_sticky_hold: assert property (
        (isr_reg[g][`XEL_ISR_IBMA] && !wr_isr_w[g]) |=> isr_reg[g][`XEL_ISR_IBMA])
        else $error("Bit 7 cleared without a software write.");

      // Causes, clearing and interrupt levels of one unit.
      a_drive_one_cycle: assert property (
        (drive_reg[g] && !ib_wr_abort_w[g]) |=> !drive_reg[g])
        else $error("System error drive lasted longer than its abort.");
      a_drive_cause: assert property (
        $rose(drive_reg[g]) |-> $past(ib_wr_abort_w[g]))
        else $error("System error driven without an inbound write abort.");
      a_isr10_cause: assert property (
        $rose(isr_reg[g][`XEL_ISR_SERR_ASSERTED]) |-> $past(ib_wr_abort_w[g]))
        else $error("Bit 10 set without an inbound write abort.");
      a_ibma_cause: assert property (
        $rose(isr_reg[g][`XEL_ISR_IBMA]) |-> $past(ib_ma_w[g]))
        else $error("Bit 7 set without an inbound master abort.");
      a_bit4_masked: assert property (
        (isr_reg[g] == (`XEL_ISR_W1C_BITS & 16'h0010) && control_reg[`XEL_CTL_P_DET_MASK + g]
         && !ib_ma_w[g] && !ib_wr_abort_w[g] && !bus_req.wr) |=> !irq_u_reg[g])
        else $error("Masked bit 4 still raised the interrupt.");
      a_bit10_raise: assert property (
        (isr_reg[g][`XEL_ISR_SERR_ASSERTED] && !mask_reg[g][`XEL_MASK_SERR_ASSERTED]) |-> irq_u_reg[g])
        else $error("Unmasked bit 10 did not raise the interrupt.");
      a_bit4_raise: assert property (
        (isr_reg[g][`XEL_ISR_SERR_DETECTED] && !control_reg[`XEL_CTL_P_DET_MASK + g]) |-> irq_u_reg[g])
        else $error("Unmasked bit 4 did not raise the interrupt.");
      a_irq_needs_bit: assert property (
        irq_u_reg[g] |-> (isr_reg[g] != `XEL_RST_REG))
        else $error("Interrupt raised with no status bit set.");
      a_isr_clear: assert property (
        (wr_isr_w[g] && wr_word[`XEL_ISR_IBMA] && !ib_ma_w[g]) |=> !isr_reg[g][`XEL_ISR_IBMA])
        else $error("Written one did not clear bit 7.");
      a_status_clear: assert property (
        (wr_status_w[g] && wr_word[`XEL_SR_SERR_ASSERTED] && !ib_wr_abort_w[g]) |=> !status_reg[g][`XEL_SR_SERR_ASSERTED])
        else $error("Written one did not clear status bit 14.");
      a_reserved_zero: assert property (
        ((isr_reg[g] & ~`XEL_ISR_W1C_BITS) == `XEL_RST_REG)
        && ((status_reg[g] & ~`XEL_SR_W1C_BITS) == `XEL_RST_REG))
        else $error("A bit outside the logged set was found set.");
      a_mask_write: assert property (
        (bus_req.wr && wr_dec.sel == XEL_SEL_MASK && wr_dec.unit == g) |=> mask_reg[g] == $past(wr_word))
        else $error("Mask register did not take the written value.");
      a_status_sticky: assert property (
        (status_reg[g][`XEL_SR_SERR_ASSERTED] && !wr_status_w[g]) |=> status_reg[g][`XEL_SR_SERR_ASSERTED])
        else $error("Status bit 14 cleared without a software write.");
      a_bit10_sticky: assert property (
        (isr_reg[g][`XEL_ISR_SERR_ASSERTED] && !wr_isr_w[g]) |=> isr_reg[g][`XEL_ISR_SERR_ASSERTED])
        else $error("Bit 10 cleared without a software write.");
      a_bit4_sticky: assert property (
        (isr_reg[g][`XEL_ISR_SERR_DETECTED] && !wr_isr_w[g]) |=> isr_reg[g][`XEL_ISR_SERR_DETECTED])
        else $error("Bit 4 cleared without a software write.");

      c_ib_write_abort: cover property (ib_wr_abort_w[g] ##1 drive_reg[g] ##1 irq_u_reg[g]);
      c_ib_read_abort: cover property (abort_w[g].ib_rd_ma ##1 isr_reg[g][`XEL_ISR_IBMA]);
      c_clear_bit: cover property (isr_reg[g][`XEL_ISR_IBMA] && wr_isr_w[g] ##1 !isr_reg[g][`XEL_ISR_IBMA]);
      c_set_over_clear: cover property (ib_ma_w[g] && wr_isr_w[g] && wr_word[`XEL_ISR_IBMA]);
      c_pin_detect: cover property (!sync2_reg[g] ##1 isr_reg[g][`XEL_ISR_SERR_DETECTED]);
    end
  endgenerate

  // Read data stands in the cycle after the read strobe; unmapped reads give zero.
  always_comb begin
    rdata_next = `XEL_RST_WORD;
    if (bus_req.rd) begin
      if (rd_dec.sel == XEL_SEL_STATUS) begin
        rdata_next[`XEL_REG_W-1:0] = status_reg[rd_dec.unit];
      end else if (rd_dec.sel == XEL_SEL_ISR) begin
        rdata_next[`XEL_REG_W-1:0] = isr_reg[rd_dec.unit];
      end else if (rd_dec.sel == XEL_SEL_MASK) begin
        rdata_next[`XEL_REG_W-1:0] = mask_reg[rd_dec.unit];
      end else if (rd_dec.sel == XEL_SEL_CONTROL) begin
        rdata_next[`XEL_REG_W-1:0] = control_reg;
      end
    end
    irq_next = irq_u_next[0] | irq_u_next[1];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= `XEL_RST_WORD;
      irq_reg   <= `XEL_BIT_CLR;
    end else begin
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
    end
  end

  // Register port checks.
  a_control_write: assert property (
    (bus_req.wr && wr_dec.sel == XEL_SEL_CONTROL)
    |=> control_reg == $past(wr_word))
    else $error("Control register did not take the written value.");
  a_rdata_status: assert property (
    (bus_req.rd && rd_dec.sel == XEL_SEL_STATUS)
    |=> bus_rdata[`XEL_REG_W-1:0] == $past(status_reg[rd_dec.unit]))
    else $error("Status read returned the wrong value.");
  a_rdata_isr: assert property (
    (bus_req.rd && rd_dec.sel == XEL_SEL_ISR)
    |=> bus_rdata[`XEL_REG_W-1:0] == $past(isr_reg[rd_dec.unit]))
    else $error("Interrupt status read returned the wrong value.");
  a_rdata_mask: assert property (
    (bus_req.rd && rd_dec.sel == XEL_SEL_MASK)
    |=> bus_rdata[`XEL_REG_W-1:0] == $past(mask_reg[rd_dec.unit]))
    else $error("Mask read returned the wrong value.");

  // All outputs come straight from flip-flops.
  assign bus_rdata                    = rdata_reg;
  assign primary_system_error_n_out   = pin_out_reg[0];
  assign primary_system_error_n_oe    = drive_reg[0];
  assign secondary_system_error_n_out = pin_out_reg[1];
  assign secondary_system_error_n_oe  = drive_reg[1];
  assign primary_irq                  = irq_u_reg[0];
  assign secondary_irq                = irq_u_reg[1];
  assign irq                          = irq_reg;

endmodule : xel_top

// ==== tb/xel_far_end.sv ====
// Far-side model: internal-bus abort source and the two pulled-up system error wires.
// Assumes fire is a one-cycle request from the bench, changed just after a rising edge of clk.
`timescale 1ns/1ps
module xel_far_end import xel_pkg::*; (
  // Clock.
  input  wire logic       clk,
  // Bench request.
  input  wire logic       fire,
  input  wire logic       unit,
  input  wire logic [3:0] kind,
  // Design pin drives, index 0 primary.
  input  wire logic [1:0] drv_out,
  input  wire logic [1:0] drv_oe,
  // Model outputs.
  output xel_abort_t      abort_p,
  output xel_abort_t      abort_s,
  output logic [1:0]      pin_lvl
);
  logic [1:0] pull_cnt;
  logic       pull_unit;

  initial begin
    abort_p   = '0;
    abort_s   = '0;
    pull_cnt  = 2'h0;
    pull_unit = 1'b0;
  end

  // Kinds 0 to 7 pulse one abort for one cycle; kind 8 pulls the unit's wire low for two cycles.
  always @(posedge clk) begin
    abort_p <= (fire && !unit && kind < 4'h8) ? xel_abort_t'(8'h80 >> kind) : '0;
    abort_s <= (fire && unit && kind < 4'h8) ? xel_abort_t'(8'h80 >> kind) : '0;
    if (fire && kind == 4'h8) begin
      pull_cnt  <= 2'h2;
      pull_unit <= unit;
    end else if (pull_cnt != 2'h0) begin
      pull_cnt <= pull_cnt - 2'h1;
    end
  end

  // The wire has a pull-up, so it reads low only while some party drives it low.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_lvl[i] = !((drv_oe[i] && !drv_out[i]) || (pull_cnt != 2'h0 && pull_unit == i[0]));
    end
  end
endmodule : xel_far_end

// ==== tb/xel_top_bench.sv ====
// Self-checking bench for the error logging block against a behavioural register model.
// Assumes the register map, bit positions and timing of the design's configuration header.
`timescale 1ns/1ps
`include "xel_cfg.svh"
module xel_top_bench import xel_pkg::*;;
  logic         clk;
  logic         sys_rst;
  xel_bus_req_t req;
  logic [31:0]  rdata;
  xel_abort_t   ab_p;
  xel_abort_t   ab_s;
  logic [1:0]   pin_lvl;
  logic [1:0]   drv_out;
  logic [1:0]   drv_oe;
  logic         irq_p;
  logic         irq_s;
  logic         irq;
  logic         ev_fire;
  logic         ev_unit;
  logic [3:0]   ev_kind;
  int           err_total;
  int           total_checks;
  int           st[2];
  int           isr[2];
  int           msk[2];
  int           ctl;
  logic [31:0]  d;
  logic         pend;

  xel_top xel_top_i (.clk(clk), .sys_rst(sys_rst), .bus_req(req), .bus_rdata(rdata),
    .primary_abort(ab_p), .secondary_abort(ab_s),
    .primary_system_error_n_in(pin_lvl[0]), .primary_system_error_n_out(drv_out[0]),
    .primary_system_error_n_oe(drv_oe[0]), .secondary_system_error_n_in(pin_lvl[1]),
    .secondary_system_error_n_out(drv_out[1]), .secondary_system_error_n_oe(drv_oe[1]),
    .primary_irq(irq_p), .secondary_irq(irq_s), .irq(irq));
  xel_far_end xel_far_end_i (.clk(clk), .fire(ev_fire), .unit(ev_unit), .kind(ev_kind),
    .drv_out(drv_out), .drv_oe(drv_oe), .abort_p(ab_p), .abort_s(ab_s), .pin_lvl(pin_lvl));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) begin
      req.wr    <= 1'b1;
      req.addr  <= a;
      req.wdata <= v;
    end
    @(posedge clk) req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) begin
      req.rd   <= 1'b1;
      req.addr <= a;
    end
    @(posedge clk) req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    void'($urandom(66));
    err_total = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    req = '0;
    ev_fire = 1'b0;
    ev_unit = 1'b0;
    ev_kind = 4'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i), d);
      chk("reset value", 32'h0000_0000, d);
    end
    wr(8'h1C, 32'h0000_FFFF);
    rd(8'h1C, d);
    chk("unmapped read", 32'h0000_0000, d);
    for (int r = 0; r < 2; r++) begin
      for (int u = 0; u < 2; u++) begin
        for (int k = 0; k < 9; k++) begin
          msk[u] = $urandom & 32'h0000_FFFF;
          ctl = $urandom & 32'h0000_FFFF;
          wr(u ? `XEL_OFS_S_MASK : `XEL_OFS_P_MASK, msk[u]);
          wr(`XEL_OFS_CONTROL, ctl);
          rd(u ? `XEL_OFS_S_MASK : `XEL_OFS_P_MASK, d);
          chk("mask", msk[u], d);
          @(posedge clk) begin
            ev_fire <= 1'b1;
            ev_unit <= u[0];
            ev_kind <= 4'(k);
          end
          @(posedge clk) ev_fire <= 1'b0;
          @(posedge clk) #1;
          chk("pin enable", {31'h0, k < 2}, {31'h0, drv_oe[u]});
          chk("pin level", {31'h0, k >= 2}, {31'h0, drv_out[u]});
          repeat (6) @(posedge clk);
          #1 chk("pin released", 32'h0, {31'h0, drv_oe[u]});
          if (k < 2) begin
            st[u] = 32'h0000_4000;
          end else begin
            st[u] = 32'h0000_0000;
          end
          isr[u] = (k < 2) ? 32'h0000_0410 : 32'h0000_0000;
          if (k == 0 || k == 2) isr[u] |= 32'h0000_0080;
          if (k < 2 || k == 8) isr[u] |= 32'h0000_0010;
          pend = isr[u][`XEL_ISR_IBMA]
            || (isr[u][`XEL_ISR_SERR_ASSERTED] && !msk[u][`XEL_MASK_SERR_ASSERTED])
            || (isr[u][`XEL_ISR_SERR_DETECTED] && !ctl[`XEL_CTL_P_DET_MASK + u]);
          rd(u ? `XEL_OFS_S_STATUS : `XEL_OFS_P_STATUS, d);
          chk("status", st[u], d);
          rd(u ? `XEL_OFS_S_ISR : `XEL_OFS_P_ISR, d);
          chk("irq status", isr[u], d);
          chk("unit irq", {31'h0, pend}, {31'h0, u ? irq_s : irq_p});
          chk("other irq", 32'h0, {31'h0, u ? irq_p : irq_s});
          chk("irq", {31'h0, pend}, {31'h0, irq});
          wr(u ? `XEL_OFS_S_STATUS : `XEL_OFS_P_STATUS, 32'h0000_FFFF);
          wr(u ? `XEL_OFS_S_ISR : `XEL_OFS_P_ISR, 32'h0000_FFFF);
          rd(u ? `XEL_OFS_S_ISR : `XEL_OFS_P_ISR, d);
          chk("cleared", 32'h0000_0000, d);
          chk("irq cleared", 32'h0, {31'h0, irq});
        end
      end
    end
    final_report();
  end
endmodule : xel_top_bench
